// file: bench/test_lcfm_core.sv
// Self-checking bench for the ladder coil and flag memory core.
// Assumes the core alone on one 8 ns clock; inputs change on falling edges.
`timescale 1ns/10ps
`default_nettype none
module test_lcfm_core;
  import lcfm_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk, reset, pwr_ok, run_sw, wide, scan, fault, run;
  lcfm_coil_s cmd;
  lcfm_req_s req;
  lcfm_rsp_s rsp;
  logic [9:0] ret_first, ret_last, ain0, ain1, aout0, aout1;
  logic [127:0] flags;
  logic [35:0] expq[$];
  logic [35:0] e;
  logic [31:0] seed, r, v;
  int n_errors, checked, i;
  localparam logic [3:0] pw_rise = 4'h6;
  localparam logic [3:0] pw_fall = 4'h9;
  localparam logic [3:0] pw_imp = 4'hA;
  localparam logic [3:0] ex_edge = 4'h2;
  localparam logic [3:0] ex_imp = 4'h6;

  lcfm_core DUT (.CLK(clk), .RESET(reset), .POWER_OK(pwr_ok), .RUN_SWITCH(run_sw),
    .VARIANT_WIDE(wide), .SCAN_START(scan), .COIL_CMD(cmd), .ORDER_FAULT(fault),
    .MEM_REQ(req), .MEM_RSP(rsp), .RET_FIRST(ret_first), .RET_LAST(ret_last),
    .ANALOG_IN0(ain0), .ANALOG_IN1(ain1), .ANALOG_OUT0(aout0), .ANALOG_OUT1(aout1),
    .FLAG_BITS(flags), .RUN_ACTIVE(run));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Flags of the note: dont-care, error, overflow, negative.
  task automatic mem(input lcfm_op_e op, input lcfm_view_e vw, input logic [7:0] idx,
      input logic [31:0] wd, input logic [3:0] f, input logic [31:0] d);
    req <= '{1'b1, op, vw, idx, wd};
    expq.push_back({f[3:1], f[0] | (vw == VIEW_DOUBLE && d[31]), d});
    @(negedge clk);
  endtask : mem

  task automatic idle();
    req.valid <= 1'b0;
    @(negedge clk);
  endtask : idle

  task automatic coil(input logic [7:0] rung, input lcfm_coil_e fn,
      input logic [7:0] idx, input logic pw, input logic fexp);
    logic seen;
    cmd <= '{1'b1, rung, fn, idx, pw};
    @(negedge clk);
    seen = fault;
    cmd.valid <= 1'b0;
    @(negedge clk);
    seen = seen | fault;
    chk(seen, fexp);
  endtask : coil

  task automatic tick_scan();
    scan <= 1'b1;
    @(negedge clk);
    scan <= 1'b0;
    @(negedge clk);
  endtask : tick_scan

  task automatic wait_run(input logic lvl);
    int k;
    for (k = 0; k < 40 && run !== lvl; k++) @(negedge clk);
    chk(run, lvl);
  endtask : wait_run

  task automatic close_out();
    $display("Checks: %0d, errors: %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // ****************************************************************
  // Clock, watchdog and response monitor
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #20000;
    n_errors++;
    close_out();
  end

  always @(negedge clk) begin
    if (rsp.valid === 1'b1) begin
      if (expq.size() == 0) begin
        n_errors++;
        $display("Error at %0t: unexpected response", $time);
      end else begin
        e = expq.pop_front();
        if (!e[35]) chk({rsp.error, rsp.overflow, rsp.negative, rsp.rdata}, e[34:0]);
      end
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    reset = 1'b1;
    pwr_ok = 1'b1;
    run_sw = 1'b1;
    wide = 1'b0;
    scan = 1'b0;
    cmd = '0;
    req = '0;
    ret_first = 10'h014;
    ret_last = 10'h014;
    ain0 = 10'h000;
    ain1 = 10'h000;
    seed = 32'h0000005D;
    repeat (10) @(negedge clk);
    reset <= 1'b0;
    mem(OP_READ, VIEW_BYTE, 8'h0D, 32'h0, 4'h4, 32'h0);
    idle();
    wait_run(1'b1);
    mem(OP_WRITE, VIEW_BYTE, 8'h0D, 32'h000000A5, 4'h0, 32'h000000A5);
    mem(OP_READ, VIEW_WORD, 8'h07, 32'h0, 4'h0, 32'h000000A5);
    mem(OP_READ, VIEW_DOUBLE, 8'h04, 32'h0, 4'h0, 32'h000000A5);
    seed = xs(seed);
    r = seed;
    seed = xs(seed);
    v = seed;
    mem(OP_WRITE, VIEW_DOUBLE, 8'h01, r, 4'h0, r);
    mem(OP_WRITE, VIEW_WORD, 8'h02, {16'h0, v[15:0]}, 4'h0, {16'h0, v[15:0]});
    mem(OP_WRITE, VIEW_BYTE, 8'h04, {24'h0, v[31:24]}, 4'h0, {24'h0, v[31:24]});
    mem(OP_READ, VIEW_DOUBLE, 8'h01, 32'h0, 4'h0, {v[31:24], v[7:0], r[15:0]});
    mem(OP_WRITE, VIEW_BIT, 8'h21, 32'h1, 4'h0, 32'h1);
    mem(OP_READ, VIEW_BYTE, 8'h05, 32'h0, 4'h0, 32'h1);
    mem(OP_WRITE, VIEW_BYTE, 8'h60, 32'h3C, 4'h0, 32'h3C);
    mem(OP_READ, VIEW_BYTE, 8'h61, 32'h0, 4'h4, 32'h0);
    mem(OP_READ, VIEW_WORD, 8'h00, 32'h0, 4'h4, 32'h0);
    mem(OP_WRITE, VIEW_DOUBLE, 8'h0A, 32'h7FFFFFFF, 4'h0, 32'h7FFFFFFF);
    mem(OP_ADD, VIEW_DOUBLE, 8'h0A, 32'h1, 4'h3, 32'h80000000);
    mem(OP_WRITE, VIEW_DOUBLE, 8'h0B, 32'h0, 4'h0, 32'h0);
    mem(OP_SUB, VIEW_DOUBLE, 8'h0B, 32'h1, 4'h1, 32'hFFFFFFFF);
    mem(OP_WRITE, VIEW_BYTE, 8'h1E, 32'hFF, 4'h0, 32'hFF);
    mem(OP_ADD, VIEW_BYTE, 8'h1E, 32'h1, 4'h2, 32'h0);
    mem(OP_WRITE, VIEW_WORD, 8'h14, 32'h0, 4'h0, 32'h0);
    mem(OP_SUB, VIEW_WORD, 8'h14, 32'h1, 4'h2, 32'hFFFF);
    idle();
    chk(flags[32:0], {1'b1, v[31:24], v[7:0], r[15:0]});
    seed = xs(seed);
    ain0 <= seed[9:0];
    ain1 <= seed[25:16];
    @(negedge clk);
    tick_scan();
    mem(OP_READ, VIEW_WORD, 8'h5D, 32'h0, 4'h0, {22'h0, ain0});
    mem(OP_READ, VIEW_WORD, 8'h5E, 32'h0, 4'h0, {22'h0, ain1});
    mem(OP_WRITE, VIEW_WORD, 8'h5D, 32'hFFFF, 4'h8, 32'h0);
    mem(OP_READ, VIEW_WORD, 8'h5D, 32'h0, 4'h0, {22'h0, ain0});
    mem(OP_WRITE, VIEW_WORD, 8'h5F, {22'h0, r[9:0]}, 4'h0, {22'h0, r[9:0]});
    mem(OP_WRITE, VIEW_WORD, 8'h60, {22'h0, v[9:0]}, 4'h0, {22'h0, v[9:0]});
    idle();
    tick_scan();
    chk(aout0, r[9:0]);
    chk(aout1, v[9:0]);
    tick_scan();
    coil(8'h01, COIL_SET, 8'h28, 1'b1, 1'b0);
    chk(flags[39], 1'b1);
    coil(8'h02, COIL_SET, 8'h28, 1'b0, 1'b0);
    chk(flags[39], 1'b1);
    coil(8'h03, COIL_RESET, 8'h28, 1'b1, 1'b0);
    chk(flags[39], 1'b0);
    tick_scan();
    coil(8'h03, COIL_SET, 8'h29, 1'b1, 1'b0);
    coil(8'h05, COIL_RESET, 8'h29, 1'b1, 1'b0);
    chk(flags[40], 1'b0);
    tick_scan();
    coil(8'h03, COIL_RESET, 8'h29, 1'b1, 1'b0);
    coil(8'h05, COIL_SET, 8'h29, 1'b1, 1'b0);
    chk(flags[40], 1'b1);
    coil(8'h04, COIL_CONTACTOR, 8'h2A, 1'b1, 1'b1);
    chk(flags[41], 1'b0);
    coil(8'h05, COIL_NEGATED, 8'h2A, 1'b1, 1'b0);
    chk(flags[41], 1'b0);
    coil(8'h06, COIL_NEGATED, 8'h2A, 1'b0, 1'b0);
    chk(flags[41], 1'b1);
    coil(8'h07, COIL_CONTACTOR, 8'h2B, 1'b1, 1'b0);
    chk(flags[42], 1'b1);
    coil(8'h08, COIL_CONTACTOR, 8'h2B, 1'b0, 1'b0);
    chk(flags[42], 1'b0);
    for (i = 0; i < 4; i++) begin
      tick_scan();
      coil(8'h10, COIL_PULSE_RISE, 8'h2C, pw_rise[i], 1'b0);
      coil(8'h11, COIL_PULSE_FALL, 8'h2D, pw_fall[i], 1'b0);
      coil(8'h12, COIL_IMPULSE, 8'h2E, pw_imp[i], 1'b0);
      chk(flags[43], ex_edge[i]);
      chk(flags[44], ex_edge[i]);
      chk(flags[45], ex_imp[i]);
    end
    mem(OP_WRITE, VIEW_BYTE, 8'h14, {24'h0, r[7:0]}, 4'h0, {24'h0, r[7:0]});
    mem(OP_WRITE, VIEW_BYTE, 8'h15, 32'h5A, 4'h0, 32'h5A);
    idle();
    run_sw <= 1'b0;
    @(negedge clk);
    wait_run(1'b0);
    @(negedge clk);
    chk(flags[40], 1'b0);
    mem(OP_READ, VIEW_BYTE, 8'h14, 32'h0, 4'h4, 32'h0);
    idle();
    run_sw <= 1'b1;
    @(negedge clk);
    wait_run(1'b1);
    mem(OP_READ, VIEW_BYTE, 8'h14, 32'h0, 4'h0, {24'h0, r[7:0]});
    mem(OP_READ, VIEW_BYTE, 8'h15, 32'h0, 4'h0, 32'h0);
    idle();
    reset <= 1'b1;
    wide <= 1'b1;
    repeat (3) @(negedge clk);
    reset <= 1'b0;
    wait_run(1'b1);
    mem(OP_WRITE, VIEW_BYTE, 8'h80, 32'hC3, 4'h0, 32'hC3);
    mem(OP_READ, VIEW_DOUBLE, 8'h20, 32'h0, 4'h0, 32'hC3000000);
    mem(OP_READ, VIEW_BYTE, 8'h81, 32'h0, 4'h4, 32'h0);
    mem(OP_WRITE, VIEW_WORD, 8'h5D, 32'h1234, 4'h0, 32'h1234);
    mem(OP_WRITE, VIEW_WORD, 8'h5F, 32'h0155, 4'h0, 32'h0155);
    idle();
    tick_scan();
    mem(OP_READ, VIEW_WORD, 8'h5D, 32'h0, 4'h0, 32'h1234);
    idle();
    chk({aout1, aout0}, 20'h0);
    coil(8'h01, COIL_CONTACTOR, 8'h80, 1'b1, 1'b0);
    chk(flags[127], 1'b1);
    repeat (3) @(negedge clk);
    chk(expq.size(), 35'h0);
    close_out();
  end
endmodule : test_lcfm_core
`default_nettype wire

// file: logic/lcfm_core.sv
// Coil evaluation and overlaid flag memory of a cyclically scanned ladder controller.
// Assumes coil commands and program requests come from logic on CLK; supply, mode
// and variant arrive on pins and are synchronised here.
//
// Contract
// - Power loss or stop clears all coils and flags except the retentive range.
// - Set coil turns on with power and stays on until reset.
// - Set and reset in one scan: the higher rung decides.
// - Negated contactor drives the inverse of its input power flow.
// - Rising pulse coil is 1 for one scan after a 0 to 1 input.
// - Falling pulse coil is 1 for one scan after a 1 to 0 input.
// - Flags are seen as bits, bytes, words and double words over one store.
// - Bit n lies in byte, word and double word found by rounding division up.
// - Byte n holds bits 8n-7..8n; larger views hold consecutive smaller ones.
// - 96 or 128 indices per view, by variant, all readable and, except the standard variant's analog input words, writable.
// - Overlapping writes in one scan keep the last write executed.
// - Standard variant: words 93-94 are read-only analog inputs, 95-96 analog outputs, 10 bits.
// - One contiguous byte range is retentive; wide variant at most 400 of 512.
// - Bytes and words are unsigned; a sign is lost in narrow views.
// - Arithmetic is signed 32-bit two's complement.
// - The top bit of a double word is its sign.
// - Plain contactor drives its input power flow directly.
// - Impulse relay toggles on each 0 to 1 input change.
`timescale 1ns/10ps
`default_nettype none
module lcfm_core
  import lcfm_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET,
  // Supply, mode and variant pins.
  input wire logic POWER_OK,
  input wire logic RUN_SWITCH,
  input wire logic VARIANT_WIDE,
  // Scan sequencer.
  input wire logic SCAN_START,
  input wire lcfm_coil_s COIL_CMD,
  output logic ORDER_FAULT,
  // Program access to the flag memory.
  input wire lcfm_req_s MEM_REQ,
  output lcfm_rsp_s MEM_RSP,
  // Retentive range, in flag bytes.
  input wire logic [9:0] RET_FIRST,
  input wire logic [9:0] RET_LAST,
  // Analog expansion.
  input wire logic [ANA_W-1:0] ANALOG_IN0,
  input wire logic [ANA_W-1:0] ANALOG_IN1,
  output logic [ANA_W-1:0] ANALOG_OUT0,
  output logic [ANA_W-1:0] ANALOG_OUT1,
  // Controller state.
  output logic [FLAG_BITS_W-1:0] FLAG_BITS,
  output logic RUN_ACTIVE
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [11:0] step_of(input lcfm_view_e v);
    case (v)
      VIEW_BIT: step_of = BIT_STEP;
      VIEW_BYTE: step_of = BYTE_STEP;
      VIEW_WORD: step_of = WORD_STEP;
      default: step_of = DOUBLE_STEP;
    endcase
  endfunction : step_of

  function automatic logic [31:0] mask_of(input lcfm_view_e v);
    case (v)
      VIEW_BIT: mask_of = BIT_MASK;
      VIEW_BYTE: mask_of = BYTE_MASK;
      VIEW_WORD: mask_of = WORD_MASK;
      default: mask_of = DOUBLE_MASK;
    endcase
  endfunction : mask_of

  // ****************************************************************
  // Declarations
  // ****************************************************************
  lcfm_mem_t mem_r;
  lcfm_mem_t mem_a;
  lcfm_mem_t mem_nxt;
  lcfm_mem_t ret_bits;
  logic [FLAG_BITS_W-1:0] prev_r;
  logic [SYNC_STAGES-1:0] pow_sync_r;
  logic [SYNC_STAGES-1:0] run_sync_r;
  logic [SYNC_STAGES-1:0] strap_sync_r;
  logic pow_r;
  logic mode_r;
  logic run_r;
  logic wide_r;
  logic strap_done_r;
  logic [1:0] strap_cnt_r;
  logic seen_r;
  logic [7:0] last_rung_r;
  logic [7:0] limit;
  logic ret_ok;
  logic req_ok;
  logic mem_wr;
  logic [11:0] req_base;
  logic [31:0] req_mask;
  logic [31:0] old_val;
  logic [31:0] new_val;
  logic [31:0] res;
  logic ovf;
  logic coil_in;
  logic coil_acc;
  logic coil_late;
  logic [11:0] cpos;
  logic coil_cur;
  logic coil_prev;
  logic coil_val;

  // ****************************************************************
  // Pin synchronisers and variant strap
  // ****************************************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pow_sync_r <= '0;
      run_sync_r <= '0;
      strap_sync_r <= '0;
    end else begin
      pow_sync_r <= {pow_sync_r[1:0], POWER_OK};
      run_sync_r <= {run_sync_r[1:0], RUN_SWITCH};
      strap_sync_r <= {strap_sync_r[1:0], VARIANT_WIDE};
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pow_r <= 1'b0;
      mode_r <= 1'b0;
    end else begin
      if (pow_sync_r[1] == pow_sync_r[2]) begin
        pow_r <= pow_sync_r[2];
      end
      if (run_sync_r[1] == run_sync_r[2]) begin
        mode_r <= run_sync_r[2];
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      strap_cnt_r <= '0;
      strap_done_r <= 1'b0;
      wide_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == STRAP_WAIT) begin
        strap_done_r <= 1'b1;
        wide_r <= strap_sync_r[2];
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      run_r <= 1'b0;
    end else begin
      run_r <= pow_r & mode_r & strap_done_r;
    end
  end

  // ****************************************************************
  // Retentive range and index limits
  // ****************************************************************
  assign limit = wide_r ? IDX_WIDE : IDX_STD;
  always_comb begin
    ret_ok = (RET_FIRST != '0) && (RET_LAST >= RET_FIRST);
    if (wide_r) begin
      ret_ok = ret_ok && (RET_LAST <= RET_WIDE_LAST) && (RET_LAST - RET_FIRST < RET_WIDE_SPAN);
    end else begin
      ret_ok = ret_ok && (RET_LAST <= RET_STD_LAST);
    end
    for (int b = 0; b < MEM_BYTES; b++) begin
      ret_bits[8*b +: 8] = {8{ret_ok && (10'(b + 1) >= RET_FIRST) && (10'(b + 1) <= RET_LAST)}};
    end
  end

  // ****************************************************************
  // Program access to the overlaid views
  // ****************************************************************
  assign req_ok = run_r && (MEM_REQ.index != '0) && (MEM_REQ.index <= limit);
  assign mem_wr = MEM_REQ.valid && req_ok && (MEM_REQ.op != OP_READ);
  assign req_base = 12'((12'(MEM_REQ.index) - 12'h001) * step_of(MEM_REQ.view));
  assign req_mask = mask_of(MEM_REQ.view);

  always_comb begin
    old_val = 32'(mem_r >> req_base) & req_mask;
    res = old_val;
    ovf = 1'b0;
    case (MEM_REQ.op)
      OP_WRITE: res = MEM_REQ.wdata;
      OP_ADD: begin
        res = old_val + MEM_REQ.wdata;
        ovf = (old_val[31] == MEM_REQ.wdata[31]) && (res[31] != old_val[31]);
      end
      OP_SUB: begin
        res = old_val - MEM_REQ.wdata;
        ovf = (old_val[31] != MEM_REQ.wdata[31]) && (res[31] != old_val[31]);
      end
      default: res = old_val;
    endcase
    if (MEM_REQ.view != VIEW_DOUBLE) begin
      ovf = |(res & ~req_mask);
    end
    new_val = res & req_mask;
    mem_a = mem_r;
    if (mem_wr) begin
      mem_a = (mem_r & ~(lcfm_mem_t'(req_mask) << req_base))
              | (lcfm_mem_t'(new_val) << req_base);
    end
  end

  // ****************************************************************
  // Coil evaluation
  // ****************************************************************
  assign coil_in = COIL_CMD.valid && run_r && (COIL_CMD.index != '0) && (COIL_CMD.index <= limit);
  assign coil_late = seen_r && !SCAN_START && (COIL_CMD.rung < last_rung_r);
  assign coil_acc = coil_in && !coil_late;
  assign cpos = 12'(COIL_CMD.index) - 12'h001;
  assign coil_cur = mem_a[cpos];
  assign coil_prev = prev_r[7'(cpos)];

  always_comb begin
    case (COIL_CMD.func)
      COIL_CONTACTOR: coil_val = COIL_CMD.power;
      COIL_NEGATED: coil_val = !COIL_CMD.power;
      COIL_SET: coil_val = COIL_CMD.power | coil_cur;
      COIL_RESET: coil_val = !COIL_CMD.power & coil_cur;
      COIL_IMPULSE: coil_val = coil_cur ^ (COIL_CMD.power & !coil_prev);
      COIL_PULSE_RISE: coil_val = COIL_CMD.power & !coil_prev;
      COIL_PULSE_FALL: coil_val = !COIL_CMD.power & coil_prev;
      default: coil_val = coil_cur;
    endcase
  end

  always_comb begin
    mem_nxt = mem_a;
    if (coil_acc) begin
      mem_nxt[cpos] = coil_val;
    end
    if (!wide_r) begin
      mem_nxt[AIN_LSB +: AIN_BITS] = mem_r[AIN_LSB +: AIN_BITS];
      if (SCAN_START && run_r) begin
        mem_nxt[AIN_LSB +: AIN_BITS] = {6'h00, ANALOG_IN1, 6'h00, ANALOG_IN0};
      end
    end
    if (!run_r) begin
      mem_nxt = mem_r & ret_bits;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mem_r <= '0;
    end else begin
      mem_r <= mem_nxt;
    end
  end

  // ****************************************************************
  // Scan order and previous-scan input tracking
  // ****************************************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      prev_r <= '0;
      seen_r <= 1'b0;
      last_rung_r <= '0;
      ORDER_FAULT <= 1'b0;
    end else if (!run_r) begin
      prev_r <= '0;
      seen_r <= 1'b0;
      last_rung_r <= '0;
      ORDER_FAULT <= 1'b0;
    end else begin
      ORDER_FAULT <= coil_in && coil_late;
      if (SCAN_START) begin
        seen_r <= 1'b0;
      end
      if (coil_acc) begin
        prev_r[7'(cpos)] <= COIL_CMD.power;
        seen_r <= 1'b1;
        last_rung_r <= COIL_CMD.rung;
      end
    end
  end

  // ****************************************************************
  // Program answer and analog outputs
  // ****************************************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      MEM_RSP <= '0;
    end else begin
      MEM_RSP.valid <= MEM_REQ.valid;
      MEM_RSP.error <= MEM_REQ.valid && !req_ok;
      MEM_RSP.overflow <= MEM_REQ.valid && req_ok && (MEM_REQ.op != OP_READ) && ovf;
      MEM_RSP.negative <= MEM_REQ.valid && req_ok && (MEM_REQ.view == VIEW_DOUBLE)
                          && new_val[31];
      MEM_RSP.rdata <= (MEM_REQ.valid && req_ok) ? new_val : '0;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ANALOG_OUT0 <= '0;
      ANALOG_OUT1 <= '0;
    end else if (wide_r) begin
      ANALOG_OUT0 <= '0;
      ANALOG_OUT1 <= '0;
    end else if (SCAN_START || !run_r) begin
      ANALOG_OUT0 <= mem_r[AOUT0_LSB +: ANA_W];
      ANALOG_OUT1 <= mem_r[AOUT1_LSB +: ANA_W];
    end
  end

  assign FLAG_BITS = mem_r[FLAG_BITS_W-1:0];
  assign RUN_ACTIVE = run_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  stop_clears_a: assert property (!run_r |=> ((mem_r & ~$past(ret_bits)) == '0))
    else $error("Non-retentive flag survived stop or power loss.");

  set_holds_a: assert property (coil_acc && COIL_CMD.func == COIL_SET && COIL_CMD.power
    |=> mem_r[$past(cpos)] ##1 (mem_r[$past(cpos, 2)] || !run_r || $past(mem_wr || coil_acc)))
    else $error("Set coil did not latch.");

  reset_wins_a: assert property (coil_acc && COIL_CMD.func == COIL_RESET && COIL_CMD.power
    |=> !mem_r[$past(cpos)])
    else $error("Later reset coil did not clear the relay.");

  negated_a: assert property (coil_acc && COIL_CMD.func == COIL_NEGATED
    |=> mem_r[$past(cpos)] == !$past(COIL_CMD.power))
    else $error("Negated coil not inverse of its input.");

  rise_pulse_a: assert property (coil_acc && COIL_CMD.func == COIL_PULSE_RISE
    |=> mem_r[$past(cpos)] == $past(COIL_CMD.power && !coil_prev))
    else $error("Rising pulse coil wrong.");

  fall_pulse_a: assert property (coil_acc && COIL_CMD.func == COIL_PULSE_FALL
    |=> mem_r[$past(cpos)] == $past(!COIL_CMD.power && coil_prev))
    else $error("Falling pulse coil wrong.");

  contactor_a: assert property (coil_acc && COIL_CMD.func == COIL_CONTACTOR
    |=> mem_r[$past(cpos)] == $past(COIL_CMD.power))
    else $error("Contactor coil does not follow its input.");

  impulse_a: assert property (coil_acc && COIL_CMD.func == COIL_IMPULSE
    && COIL_CMD.power && !coil_prev |=> mem_r[$past(cpos)] != $past(coil_cur))
    else $error("Impulse relay did not toggle.");

  order_a: assert property (coil_in && coil_late |=> ORDER_FAULT ##1 !ORDER_FAULT || $past(coil_in))
    else $error("Out-of-order rung not flagged.");

  analog_ro_a: assert property (run_r && !wide_r && !SCAN_START && run_r
    |=> mem_r[AIN_LSB +: AIN_BITS] == $past(mem_r[AIN_LSB +: AIN_BITS]) || !$past(run_r))
    else $error("Analog input words changed outside a scan start.");

endmodule : lcfm_core
`default_nettype wire

// file: logic/lcfm_pkg.sv
// Constants, types and carriers for the ladder coil and flag memory block.
// Assumes one 125 MHz clock shared by the scan sequencer and the program port.
package lcfm_pkg;

  // ****************************************************************
  // Sizes and limits
  // ****************************************************************
  localparam int MEM_BITS = 4096;
  localparam int MEM_BYTES = 512;
  localparam int FLAG_BITS_W = 128;
  localparam int ANA_W = 10;
  localparam int SYNC_STAGES = 3;
  localparam logic [7:0] IDX_STD = 8'h60;
  localparam logic [7:0] IDX_WIDE = 8'h80;
  localparam logic [9:0] RET_STD_LAST = 10'h060;
  localparam logic [9:0] RET_WIDE_LAST = 10'h200;
  localparam logic [9:0] RET_WIDE_SPAN = 10'h190;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // ****************************************************************
  // Field positions in the flat flag storage
  // ****************************************************************
  localparam int AIN_LSB = 1472;
  localparam int AIN_BITS = 32;
  localparam int AIN1_LSB = 1488;
  localparam int AOUT0_LSB = 1504;
  localparam int AOUT1_LSB = 1520;
  localparam logic [11:0] BIT_STEP = 12'h001;
  localparam logic [11:0] BYTE_STEP = 12'h008;
  localparam logic [11:0] WORD_STEP = 12'h010;
  localparam logic [11:0] DOUBLE_STEP = 12'h020;
  localparam logic [31:0] BIT_MASK = 32'h00000001;
  localparam logic [31:0] BYTE_MASK = 32'h000000FF;
  localparam logic [31:0] WORD_MASK = 32'h0000FFFF;
  localparam logic [31:0] DOUBLE_MASK = 32'hFFFFFFFF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [MEM_BITS-1:0] lcfm_mem_t;
  typedef enum logic [2:0] {
    COIL_CONTACTOR, COIL_IMPULSE, COIL_SET, COIL_RESET,
    COIL_NEGATED, COIL_PULSE_RISE, COIL_PULSE_FALL
  } lcfm_coil_e;
  typedef enum logic [1:0] {VIEW_BIT, VIEW_BYTE, VIEW_WORD, VIEW_DOUBLE} lcfm_view_e;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ADD, OP_SUB} lcfm_op_e;

  typedef struct packed {
    logic valid;
    logic [7:0] rung;
    lcfm_coil_e func;
    logic [7:0] index;
    logic power;
  } lcfm_coil_s;

  typedef struct packed {
    logic valid;
    lcfm_op_e op;
    lcfm_view_e view;
    logic [7:0] index;
    logic [31:0] wdata;
  } lcfm_req_s;

  typedef struct packed {
    logic valid;
    logic error;
    logic overflow;
    logic negative;
    logic [31:0] rdata;
  } lcfm_rsp_s;

endpackage : lcfm_pkg
